// File: rtl/pulse_counter_defs.svh
// Constants for the reversing and quadrature pulse counter.
// Summary of operation
// - Quadrature: first input leading counts up.
// - Quadrature: first input lagging counts down.
// - Quadrature: two setpoints each switch their output.
// - Reversing: input 2 pulse flips direction.
// - Reversing: output 2 switches at setpoint 2.
// - Reversing: output 1 switches at setpoint 1.
// - Zero setpoint is disabled, never matches.
// - Reversing starts counting up after reset.
`ifndef PULSE_COUNTER_DEFS_SVH
`define PULSE_COUNTER_DEFS_SVH
`define CNT_WIDTH 32
`define CNT_RESET 32'h0000_0000
`define DIR_UP_RESET 1'b1
`define OUT_RESET 1'b0
`define EDGE_RESET 1'b0
`define SETPOINT_OFF 32'h0000_0000
`define CNT_STEP 32'h0000_0001
`endif

// File: rtl/pulse_counter_pkg.sv
// Types shared by the pulse counter modules.
package pulse_counter_pkg;
  typedef enum logic [0:0] {
    MODE_REVERSING = 1'b0,
    MODE_QUADRATURE = 1'b1
  } counter_mode_e;
  typedef logic [31:0] count_t;
endpackage

// File: rtl/count_step_if.sv
// Step request carried from the input decoder to the counting register.
`timescale 1ns/1ns
`default_nettype none
interface count_step_if;
  logic step;
  logic up;
  modport src (output step, output up);
  modport dst (input step, input up);
endinterface
`default_nettype wire

// File: rtl/count_step_decoder.sv
// Turns the two counting inputs into count steps for either mode.
`timescale 1ns/1ns
`default_nettype none
`include "pulse_counter_defs.svh"
module count_step_decoder (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Mode and inputs.
  input wire pulse_counter_pkg::counter_mode_e counter_mode_select,
  input wire logic in1,
  input wire logic in2,
  // Step request.
  count_step_if.src step_out
);
  logic in1_reg;
  logic in2_reg;
  logic dir_up_reg;
  logic rise1;
  logic rise2;

  // Previous input levels for edge detection.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in1_reg <= `EDGE_RESET;
      in2_reg <= `EDGE_RESET;
    end else begin
      in1_reg <= in1;
      in2_reg <= in2;
    end
  end

  assign rise1 = in1 & ~in1_reg;
  assign rise2 = in2 & ~in2_reg;

  // Reversing direction starts up and flips on each input 2 pulse.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_up_reg <= `DIR_UP_RESET;
    end else if (counter_mode_select == pulse_counter_pkg::MODE_REVERSING
                 && rise2) begin
      dir_up_reg <= ~dir_up_reg;
    end
  end

  // A first-input rising edge steps; quadrature direction comes from
  // input 2: low at the edge means input 1 leads.
  always_comb begin
    step_out.step = rise1;
    if (counter_mode_select == pulse_counter_pkg::MODE_QUADRATURE) begin
      step_out.up = ~in2;
    end else begin
      step_out.up = dir_up_reg;
    end
  end

  // The direction comes out of reset counting up.
  a_dir_reset: assert property (@(posedge clk)
    $fell(nrst) |=> dir_up_reg)
    else $error("Direction not up after reset.");
  // An input 2 pulse in reversing mode flips the direction.
  a_dir_flip: assert property (@(posedge clk) disable iff (!nrst)
    counter_mode_select == pulse_counter_pkg::MODE_REVERSING && rise2
    |=> dir_up_reg != $past(dir_up_reg))
    else $error("Direction did not flip on input 2 pulse.");
  // Without such a pulse the direction stays where it is.
  a_dir_hold: assert property (@(posedge clk) disable iff (!nrst)
    counter_mode_select == pulse_counter_pkg::MODE_QUADRATURE || !rise2
    |=> dir_up_reg == $past(dir_up_reg))
    else $error("Direction moved without input 2 pulse.");
endmodule
`default_nettype wire

// File: rtl/pulse_counter.sv
// Counting register with two setpoint-driven outputs.
`timescale 1ns/1ns
`default_nettype none
`include "pulse_counter_defs.svh"
module pulse_counter (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Configuration.
  input wire pulse_counter_pkg::counter_mode_e counter_mode_select,
  input wire pulse_counter_pkg::count_t setpoint1,
  input wire pulse_counter_pkg::count_t setpoint2,
  // Field inputs.
  input wire logic in1,
  input wire logic in2,
  input wire logic count_clear,
  input wire logic count_block,
  // Results.
  output logic [`CNT_WIDTH-1:0] count,
  output logic out1,
  output logic out2
);
  count_step_if step_bus ();
  logic [`CNT_WIDTH-1:0] count_next;
  logic hit1;
  logic hit2;
  logic in1_prev_reg;

  count_step_decoder decoder (
    .clk(clk),
    .nrst(nrst),
    .counter_mode_select(counter_mode_select),
    .in1(in1),
    .in2(in2),
    .step_out(step_bus.src)
  );

  // Next count: clear wins, block freezes, otherwise step up or down.
  always_comb begin
    count_next = count;
    if (count_clear) begin
      count_next = `CNT_RESET;
    end else if (!count_block && step_bus.step) begin
      if (step_bus.up) begin
        count_next = count + `CNT_STEP;
      end else begin
        count_next = count - `CNT_STEP;
      end
    end
  end

  // Counting register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= `CNT_RESET;
    end else begin
      count <= count_next;
    end
  end

  // Coincidence is judged on the value the register is about to take,
  // so each output switches at the same edge as the count does. A zero
  // setpoint never matches.
  assign hit1 = (setpoint1 != `SETPOINT_OFF)
                && (count_next == setpoint1);
  assign hit2 = (setpoint2 != `SETPOINT_OFF)
                && (count_next == setpoint2);

  // Each output holds while the register equals its setpoint.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out1 <= `OUT_RESET;
      out2 <= `OUT_RESET;
    end else begin
      out1 <= hit1;
      out2 <= hit2;
    end
  end

  // Input 1 history kept for the checks below. It clears like the
  // decoder's own history, so a high input at release reads as a pulse.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in1_prev_reg <= `EDGE_RESET;
    end else begin
      in1_prev_reg <= in1;
    end
  end

  // A first-input pulse that neither clear nor block holds back.
  sequence s_free_pulse;
    in1 && !in1_prev_reg && !count_block && !count_clear;
  endsequence

  // A free pulse in quadrature mode while input 2 is still low, that is
  // with input 1 leading.
  sequence s_quad_lead;
    s_free_pulse ##0
      (counter_mode_select == pulse_counter_pkg::MODE_QUADRATURE && !in2);
  endsequence

  // A free pulse in quadrature mode after input 2 has already risen,
  // that is with input 1 lagging.
  sequence s_quad_lag;
    s_free_pulse ##0
      (counter_mode_select == pulse_counter_pkg::MODE_QUADRATURE && in2);
  endsequence

  // A free pulse in reversing mode while the direction is up.
  sequence s_rev_up;
    s_free_pulse ##0
      (counter_mode_select == pulse_counter_pkg::MODE_REVERSING &&
       step_bus.up);
  endsequence

  // A free pulse in reversing mode while the direction is down.
  sequence s_rev_down;
    s_free_pulse ##0
      (counter_mode_select == pulse_counter_pkg::MODE_REVERSING &&
       !step_bus.up);
  endsequence

  // A cycle with neither an input 1 pulse nor a clear.
  sequence s_idle;
    !(in1 && !in1_prev_reg) && !count_clear;
  endsequence

  // Output 1 follows coincidence of the register with setpoint 1.
  property p_out1_match;
    @(posedge clk) disable iff (!nrst)
      out1 == ($past(setpoint1) != `SETPOINT_OFF &&
               count == $past(setpoint1));
  endproperty
  a_out1_match: assert property (p_out1_match)
    else $error("Output 1 does not follow setpoint 1 match.");

  // Output 2 follows coincidence of the register with setpoint 2.
  property p_out2_match;
    @(posedge clk) disable iff (!nrst)
      out2 == ($past(setpoint2) != `SETPOINT_OFF &&
               count == $past(setpoint2));
  endproperty
  a_out2_match: assert property (p_out2_match)
    else $error("Output 2 does not follow setpoint 2 match.");

  // A zero setpoint 1 keeps output 1 off.
  property p_sp1_off;
    @(posedge clk) disable iff (!nrst)
      $past(setpoint1) == `SETPOINT_OFF |-> !out1;
  endproperty
  a_zero_disabled: assert property (p_sp1_off)
    else $error("Disabled setpoint switched output.");

  // A zero setpoint 2 keeps output 2 off.
  property p_sp2_off;
    @(posedge clk) disable iff (!nrst)
      $past(setpoint2) == `SETPOINT_OFF |-> !out2;
  endproperty
  a_sp2_disabled: assert property (p_sp2_off)
    else $error("Disabled setpoint 2 switched output 2.");

  // The block input freezes the register unless a clear comes too.
  property p_block_hold;
    @(posedge clk) disable iff (!nrst)
      count_block && !count_clear |=> count == $past(count);
  endproperty
  a_block_hold: assert property (p_block_hold)
    else $error("Count moved while blocked.");

  // A clear empties the register whatever else happens.
  property p_clear_zero;
    @(posedge clk) disable iff (!nrst)
      count_clear |=> count == `CNT_RESET;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("Clear did not zero count.");

  // A leading first input steps the register up by one.
  property p_quad_up;
    @(posedge clk) disable iff (!nrst)
      s_quad_lead |=> count == $past(count) + `CNT_STEP;
  endproperty
  a_quad_up: assert property (p_quad_up)
    else $error("Quadrature did not count up.");

  // A lagging first input steps the register down by one.
  property p_quad_down;
    @(posedge clk) disable iff (!nrst)
      s_quad_lag |=> count == $past(count) - `CNT_STEP;
  endproperty
  a_quad_down: assert property (p_quad_down)
    else $error("Quadrature did not count down.");

  // In quadrature mode a match of setpoint 1 alone raises output 1 only.
  property p_quad_out1;
    @(posedge clk) disable iff (!nrst)
      $past(counter_mode_select) == pulse_counter_pkg::MODE_QUADRATURE &&
      $past(setpoint1) != `SETPOINT_OFF && count == $past(setpoint1) &&
      count != $past(setpoint2) |-> out1 && !out2;
  endproperty
  a_quad_outputs: assert property (p_quad_out1)
    else $error("Setpoint 1 hit not shown on output 1 alone.");

  // In quadrature mode a match of setpoint 2 alone raises output 2 only.
  property p_quad_out2;
    @(posedge clk) disable iff (!nrst)
      $past(counter_mode_select) == pulse_counter_pkg::MODE_QUADRATURE &&
      $past(setpoint2) != `SETPOINT_OFF && count == $past(setpoint2) &&
      count != $past(setpoint1) |-> out2 && !out1;
  endproperty
  a_quad_out2: assert property (p_quad_out2)
    else $error("Setpoint 2 hit not shown on output 2 alone.");

  // Reversing mode counts up while the direction is up.
  property p_rev_up;
    @(posedge clk) disable iff (!nrst)
      s_rev_up |=> count == $past(count) + `CNT_STEP;
  endproperty
  a_rev_up: assert property (p_rev_up)
    else $error("Reversing did not count up.");

  // Reversing mode counts down once the direction has turned.
  property p_rev_down;
    @(posedge clk) disable iff (!nrst)
      s_rev_down |=> count == $past(count) - `CNT_STEP;
  endproperty
  a_rev_down: assert property (p_rev_down)
    else $error("Reversing did not count down.");

  // Without a pulse or a clear the register stands still.
  property p_count_stands;
    @(posedge clk) disable iff (!nrst)
      s_idle |=> count == $past(count);
  endproperty
  a_count_stands: assert property (p_count_stands)
    else $error("Count moved without a pulse.");

  // Reset leaves the register empty and both outputs off.
  property p_reset_idle;
    @(posedge clk)
      !nrst |=> count == `CNT_RESET && out1 == `OUT_RESET &&
        out2 == `OUT_RESET;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("Counter not idle after reset.");
endmodule
`default_nettype wire

// File: verification/encoder_model.sv
// Model of the field side: pulse sensor or two-phase encoder.
`timescale 1ns/1ns
`default_nettype none
module encoder_model (
  // Clock and command.
  input wire logic clk,
  input wire logic go,
  input wire logic a_en,
  input wire logic b_en,
  input wire logic rev,
  // Field lines.
  output wire logic in1,
  output wire logic in2
);
  logic [2:0] ph_reg = 3'h0;
  // One four-phase wave cycle per go; idle keeps both lines low.
  always @(posedge clk) begin
    if (ph_reg == 3'h4) begin
      ph_reg <= 3'h0;
    end else if (go || ph_reg != 3'h0) begin
      ph_reg <= ph_reg + 3'h1;
    end
  end
  // The rev flag makes the first line lag the second.
  assign in1 = a_en & (rev ? (ph_reg inside {3'h2, 3'h3})
                           : (ph_reg inside {3'h1, 3'h2}));
  assign in2 = b_en & (rev ? (ph_reg inside {3'h1, 3'h2})
                           : (ph_reg inside {3'h2, 3'h3}));
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the pulse counter.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic clr = 1'h0;
  logic blk = 1'h0;
  logic go = 1'h0;
  logic [2:0] cmd = 3'h0;
  logic in1, in2, out1, out2;
  pulse_counter_pkg::counter_mode_e mode = pulse_counter_pkg::MODE_REVERSING;
  pulse_counter_pkg::count_t sp1 = 32'h0000_0002;
  pulse_counter_pkg::count_t sp2 = 32'h0000_0000;
  pulse_counter_pkg::count_t count;
  int err_count = 0;
  int checks = 0;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  encoder_model i_enc (.clk(clk), .go(go), .a_en(cmd[2]), .b_en(cmd[1]),
    .rev(cmd[0]), .in1(in1), .in2(in2));
  pulse_counter i_dut (.clk(clk), .nrst(nrst), .counter_mode_select(mode),
    .setpoint1(sp1), .setpoint2(sp2), .in1(in1), .in2(in2),
    .count_clear(clr), .count_block(blk), .count(count), .out1(out1),
    .out2(out2));
  task automatic summarize;
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_cnt(input pulse_counter_pkg::count_t exp);
    checks++;
    if (count !== exp) begin
      err_count++;
      $display("Error %0t count %h not %h", $time, count, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t output %b not %b", $time, got, exp);
    end
  endtask
  // One wave cycle; cmd is {first line, second line, reversed}.
  task automatic run(input logic [2:0] c);
    cmd = c;
    go = 1'h1;
    @(posedge clk);
    #1 go = 1'h0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic clear_count;
    clr = 1'h1;
    @(posedge clk);
    #1 clr = 1'h0;
  endtask
  task automatic t_rev;
    run(3'h4);
    run(3'h4);
    chk_cnt(32'h0000_0002);
    chk_bit(out1, 1'h1);
    chk_bit(out2, 1'h0);
    run(3'h4);
    chk_bit(out1, 1'h0);
    run(3'h2);
    run(3'h4);
    chk_cnt(32'h0000_0002);
    sp2 = 32'h0000_0001;
    run(3'h4);
    chk_bit(out2, 1'h1);
  endtask
  task automatic t_quad;
    mode = pulse_counter_pkg::MODE_QUADRATURE;
    clear_count;
    chk_cnt(32'h0000_0000);
    run(3'h6);
    chk_bit(out2, 1'h1);
    run(3'h6);
    chk_cnt(32'h0000_0002);
    chk_bit(out1, 1'h1);
    chk_bit(out2, 1'h0);
    run(3'h7);
    run(3'h7);
    run(3'h7);
    chk_cnt(32'hffff_ffff);
    blk = 1'h1;
    run(3'h6);
    chk_cnt(32'hffff_ffff);
    blk = 1'h0;
  endtask
  // Reset in mid-run while counting down: the count restarts upwards.
  task automatic t_restart;
    mode = pulse_counter_pkg::MODE_REVERSING;
    nrst = 1'h0;
    @(posedge clk);
    #1 nrst = 1'h1;
    chk_cnt(32'h0000_0000);
    chk_bit(out1, 1'h0);
    run(3'h4);
    chk_cnt(32'h0000_0001);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 nrst = 1'h1;
    t_rev;
    t_quad;
    t_restart;
    summarize;
  end
  // Watchdog well beyond the 113 cycles the tests need.
  initial begin
    #200000;
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire
